/* File: hw/vpm_cfg.svh */
// Port addresses, field positions and reset values for the video plane host access block
`ifndef VPM_CFG_SVH
`define VPM_CFG_SVH
`define VPM_P_ATTR_WR      10'h3c0
`define VPM_P_ATTR_RD      10'h3c1
`define VPM_P_MISC_WR      10'h3c2
`define VPM_P_STAT0_RD     10'h3c2
`define VPM_P_SUBSYS       10'h3c3
`define VPM_P_SEQ_IDX      10'h3c4
`define VPM_P_SEQ_DAT      10'h3c5
`define VPM_P_LUT_MASK     10'h3c6
`define VPM_P_LUT_RIDX     10'h3c7
`define VPM_P_LUT_WIDX     10'h3c8
`define VPM_P_LUT_DAT      10'h3c9
`define VPM_P_FEAT_RD      10'h3ca
`define VPM_P_MISC_RD      10'h3cc
`define VPM_P_GFX_IDX      10'h3ce
`define VPM_P_GFX_DAT      10'h3cf
`define VPM_P_CRT_IDX_LO   4'h4
`define VPM_P_CRT_DAT_LO   4'h5
`define VPM_P_STAT1_LO     4'ha
`define VPM_P_MONO_HI      6'h3b
`define VPM_P_COLR_HI      6'h3d
`define VPM_SEQ_MAPMASK    3'h2
`define VPM_GFX_CMPCOL     4'h2
`define VPM_GFX_RDMAP      4'h4
`define VPM_GFX_MODE       4'h5
`define VPM_GFX_DONTCARE   4'h7
`define VPM_GFX_MODE_RDBIT 3
`define VPM_MISC_IOSEL     0
`define VPM_MISC_RAMEN     1
`define VPM_MISC_CLK_LSB   2
`define VPM_MISC_HPOL      6
`define VPM_MISC_VPOL      7
`define VPM_MISC_RESET     8'h00
`define VPM_SUBSYS_RESET   8'h01
`define VPM_MAPMASK_RESET  8'h0f
`define VPM_WIN_A0000      20'ha0000
`define VPM_WIN_B0000      20'hb0000
`define VPM_WIN_B8000      20'hb8000
`define VPM_LIN_BYTES      17'd64000
`endif

/* File: hw/vpm_host_access.sv */
// Host memory and I/O access to four-plane display memory
// Functional notes
// - Single-plane two-colour: 0 black, 1 bright white
// - Mono graphics: plane 0 video, plane 2 intensity
// - Mono pixel pair: black, white, blink, bright
// - Byte covers eight pixels, MSB leftmost
// - 640x480 two-colour data only in plane 0
// - Sixteen-colour planes: blue, green, red, intensity
// - Four plane bits form palette index
// - Linear 64000-byte buffer from A0000
// - Planes fetched twice form 8-bit lookup
// - Four 64KB planes share one address
// - Windows A0000 64KB, B0000 32KB, B8000 32KB
// - Plane written when decode and mask agree
// - Read mode 0 returns selected plane byte
// - Read mode 1 returns colour compare result
// - All registers readable except latches, toggle, LUT read index
// - CRT and status1 decode follow I/O select
// - Index and data port pairs other than CRT decode fixed
// - Status, feature and enable port decode
// - Misc output written 3C2, read 3CC
// - Misc output bit layout
// - Polarity bits low give positive pulses
// - Polarity pair encodes vertical size
// - Clock select field encoding
// - RAM enable low stops buffer decode
// - I/O select places CRT at 3Bx/3Dx
`timescale 1ns/1ps
`include "vpm_cfg.svh"
module vpm_host_access #(
	parameter int PLANE_AW = 16
) (
	input  wire logic                 i_mclk,
	input  wire logic                 i_arst_n,
	input  wire vpm_pkg::vpm_mem_req_s i_mem,
	input  wire vpm_pkg::vpm_io_req_s  i_io,
	input  wire logic                 i_switch_sense,
	input  wire logic                 i_vretrace,
	input  wire logic                 i_disp_en,
	input  wire logic [PLANE_AW-1:0]  i_scan_addr,
	input  wire logic                 i_scan_second,
	output logic                      o_mem_hit,
	output logic [7:0]                o_mem_rdata,
	output logic                      o_io_hit,
	output logic [7:0]                o_io_rdata,
	output logic                      o_vsync_pos,
	output logic                      o_hsync_pos,
	output vpm_pkg::vpm_vsize_e       o_vsize,
	output vpm_pkg::vpm_clk_e         o_clk_sel,
	output vpm_pkg::vpm_pix_s         o_pix
);
	localparam int PDEPTH = 1 << PLANE_AW;

	// Four independent planes on a shared byte address
	logic [7:0] plane0 [PDEPTH];
	logic [7:0] plane1 [PDEPTH];
	logic [7:0] plane2 [PDEPTH];
	logic [7:0] plane3 [PDEPTH];

	logic [7:0] misc_q;
	logic [7:0] subsys_q;
	logic [7:0] feat_q;
	logic [2:0] seq_idx_q;
	logic [7:0] seq_reg_q [8];
	logic [3:0] gfx_idx_q;
	logic [7:0] gfx_reg_q [16];
	logic [7:0] crt_idx_q;
	logic [7:0] crt_reg_q [256];
	logic [4:0] attr_idx_q;
	logic       attr_toggle_q;
	logic [7:0] attr_reg_q [32];
	logic [7:0] lut_mask_q;
	logic [7:0] lut_ridx_q;
	logic [7:0] lut_widx_q;
	logic [7:0] lut_dat_q;
	logic [7:0] mem_rdata_q;
	logic [7:0] io_rdata_q;
	vpm_pkg::vpm_pix_s pix_q;
	logic [3:0] lo_nib_q;

	logic [5:0] crt_hi;
	logic       io_sel;
	logic       ram_en;
	logic       dec_on;
	logic [1:0] win_sel;
	logic       in_win;
	logic [19:0] off;
	logic [PLANE_AW-1:0] paddr;
	logic [3:0] plane_dec;
	logic [3:0] plane_we;
	logic [1:0] rd_plane;
	logic [7:0] cmp_res;
	logic [7:0] rd0;

	assign io_sel = misc_q[`VPM_MISC_IOSEL];
	assign crt_hi = io_sel ? `VPM_P_COLR_HI : `VPM_P_MONO_HI;
	assign ram_en = misc_q[`VPM_MISC_RAMEN];
	assign dec_on = subsys_q[0];
	assign win_sel = gfx_reg_q[6][3:2];

	// Window decode; chain-4 takes two address bits as plane number
	always_comb begin
		off = 20'h00000;
		in_win = 1'b0;
		unique case (win_sel)
			2'b00: begin
				off = i_mem.addr - `VPM_WIN_A0000;
				in_win = i_mem.addr[19:17] == 3'b101;
			end
			2'b01: begin
				off = i_mem.addr - `VPM_WIN_A0000;
				in_win = i_mem.addr[19:16] == 4'ha;
			end
			2'b10: begin
				off = i_mem.addr - `VPM_WIN_B0000;
				in_win = i_mem.addr[19:15] == 5'b10110;
			end
			2'b11: begin
				off = i_mem.addr - `VPM_WIN_B8000;
				in_win = i_mem.addr[19:15] == 5'b10111;
			end
		endcase
	end

	// Chain-4 gives one byte per pixel across the planes, 64000 bytes used
	always_comb begin
		if (seq_reg_q[4][3]) begin
			paddr = PLANE_AW'(off[19:2]);
			plane_dec = 4'b0001 << off[1:0];
		end else if (!seq_reg_q[4][2]) begin
			paddr = PLANE_AW'({1'b0, off[19:1]});
			plane_dec = off[0] ? 4'b1010 : 4'b0101;
		end else begin
			paddr = PLANE_AW'(off);
			plane_dec = 4'b1111;
		end
	end

	assign o_mem_hit = i_mem.req && in_win && ram_en && dec_on;
	assign plane_we = {4{o_mem_hit && i_mem.wr}} & plane_dec
		& seq_reg_q[`VPM_SEQ_MAPMASK][3:0];

	// Planes written from host; each gated separately
	always_ff @(posedge i_mclk) begin
		if (plane_we[0])
			plane0[paddr] <= i_mem.data;
		if (plane_we[1])
			plane1[paddr] <= i_mem.data;
		if (plane_we[2])
			plane2[paddr] <= i_mem.data;
		if (plane_we[3])
			plane3[paddr] <= i_mem.data;
	end

	// Read plane: chain-4 from decode, odd/even from address bit 0 and read map bit 1, else read map select
	always_comb begin
		rd_plane = gfx_reg_q[`VPM_GFX_RDMAP][1:0];
		if (seq_reg_q[4][3])
			rd_plane = off[1:0];
		else if (!seq_reg_q[4][2])
			rd_plane = {gfx_reg_q[`VPM_GFX_RDMAP][1], off[0]};
	end

	always_comb begin
		unique case (rd_plane)
			2'd0: rd0 = plane0[paddr];
			2'd1: rd0 = plane1[paddr];
			2'd2: rd0 = plane2[paddr];
			default: rd0 = plane3[paddr];
		endcase
	end

	// Compare each pixel's four plane bits to colour, skipping don't-care planes
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			cmp_res[b] = ~|((({plane3[paddr][b], plane2[paddr][b], plane1[paddr][b],
				plane0[paddr][b]} ^ gfx_reg_q[`VPM_GFX_CMPCOL][3:0])
				& gfx_reg_q[`VPM_GFX_DONTCARE][3:0]));
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mem_rdata_q <= 8'h00;
		end else if (o_mem_hit && !i_mem.wr) begin
			if (gfx_reg_q[`VPM_GFX_MODE][`VPM_GFX_MODE_RDBIT])
				mem_rdata_q <= cmp_res;
			else
				mem_rdata_q <= rd0;
		end
	end

	assign o_mem_rdata = mem_rdata_q;

	// I/O port decode
	logic wr_io;
	logic rd_io;
	logic crt_grp;
	assign wr_io = i_io.req && i_io.wr && dec_on;
	assign rd_io = i_io.req && !i_io.wr && dec_on;
	assign crt_grp = i_io.port[9:4] == crt_hi;

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			misc_q <= `VPM_MISC_RESET;
		end else if (wr_io && i_io.port == `VPM_P_MISC_WR) begin
			misc_q <= i_io.data;
		end
	end

	// Enable port stays live so software can turn decode back on
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			subsys_q <= `VPM_SUBSYS_RESET;
		end else if (i_io.req && i_io.wr && i_io.port == `VPM_P_SUBSYS) begin
			subsys_q <= i_io.data;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			feat_q <= 8'h00;
			seq_idx_q <= 3'h0;
			gfx_idx_q <= 4'h0;
			crt_idx_q <= 8'h00;
			lut_mask_q <= 8'hff;
			lut_ridx_q <= 8'h00;
			lut_widx_q <= 8'h00;
			lut_dat_q <= 8'h00;
		end else if (wr_io) begin
			if (crt_grp && i_io.port[3:0] == `VPM_P_STAT1_LO)
				feat_q <= i_io.data;
			if (crt_grp && i_io.port[3:0] == `VPM_P_CRT_IDX_LO)
				crt_idx_q <= i_io.data;
			unique case (i_io.port)
				`VPM_P_SEQ_IDX: seq_idx_q <= i_io.data[2:0];
				`VPM_P_GFX_IDX: gfx_idx_q <= i_io.data[3:0];
				`VPM_P_LUT_MASK: lut_mask_q <= i_io.data;
				`VPM_P_LUT_RIDX: lut_ridx_q <= i_io.data;
				`VPM_P_LUT_WIDX: lut_widx_q <= i_io.data;
				`VPM_P_LUT_DAT: lut_dat_q <= i_io.data;
				default: ;
			endcase
		end
	end

	// Indexed data registers; map mask resets to all planes
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int k = 0; k < 8; k++)
				seq_reg_q[k] <= (k == 2) ? `VPM_MAPMASK_RESET : 8'h00;
			for (int k = 0; k < 16; k++)
				gfx_reg_q[k] <= 8'h00;
		end else if (wr_io) begin
			if (i_io.port == `VPM_P_SEQ_DAT)
				seq_reg_q[seq_idx_q] <= i_io.data;
			if (i_io.port == `VPM_P_GFX_DAT)
				gfx_reg_q[gfx_idx_q] <= i_io.data;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (wr_io && crt_grp && i_io.port[3:0] == `VPM_P_CRT_DAT_LO)
			crt_reg_q[crt_idx_q] <= i_io.data;
	end

	// Attribute port flips between index and data on each write
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			attr_toggle_q <= 1'b0;
			attr_idx_q <= 5'h00;
		end else if (wr_io && i_io.port == `VPM_P_ATTR_WR) begin
			attr_toggle_q <= ~attr_toggle_q;
			if (!attr_toggle_q)
				attr_idx_q <= i_io.data[4:0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (wr_io && i_io.port == `VPM_P_ATTR_WR && attr_toggle_q)
			attr_reg_q[attr_idx_q] <= i_io.data;
	end

	// Readback; toggle and latches have no read path
	logic [7:0] io_rd_d;
	logic       io_rd_hit;
	always_comb begin
		io_rd_d = 8'h00;
		io_rd_hit = 1'b1;
		if (crt_grp && i_io.port[3:0] == `VPM_P_CRT_IDX_LO)
			io_rd_d = crt_idx_q;
		else if (crt_grp && i_io.port[3:0] == `VPM_P_CRT_DAT_LO)
			io_rd_d = crt_reg_q[crt_idx_q];
		else if (crt_grp && i_io.port[3:0] == `VPM_P_STAT1_LO)
			io_rd_d = {4'h0, i_vretrace, 2'b00, ~i_disp_en};
		else begin
			unique case (i_io.port)
				`VPM_P_ATTR_WR: io_rd_d = {3'b000, attr_idx_q};
				`VPM_P_ATTR_RD: io_rd_d = attr_reg_q[attr_idx_q];
				`VPM_P_STAT0_RD: io_rd_d = {3'b000, i_switch_sense, 4'h0};
				`VPM_P_SUBSYS: io_rd_d = subsys_q;
				`VPM_P_SEQ_IDX: io_rd_d = {5'h00, seq_idx_q};
				`VPM_P_SEQ_DAT: io_rd_d = seq_reg_q[seq_idx_q];
				`VPM_P_LUT_MASK: io_rd_d = lut_mask_q;
				`VPM_P_LUT_WIDX: io_rd_d = lut_widx_q;
				`VPM_P_LUT_DAT: io_rd_d = lut_dat_q;
				`VPM_P_FEAT_RD: io_rd_d = feat_q;
				`VPM_P_MISC_RD: io_rd_d = misc_q;
				`VPM_P_GFX_IDX: io_rd_d = {4'h0, gfx_idx_q};
				`VPM_P_GFX_DAT: io_rd_d = gfx_reg_q[gfx_idx_q];
				default: io_rd_hit = 1'b0;
			endcase
		end
	end

	// Writes hit only ports that accept them; read-only ports refuse writes
	assign o_io_hit = i_io.req && dec_on && (i_io.wr
		? (io_rd_hit && !(i_io.port inside {`VPM_P_ATTR_RD, `VPM_P_FEAT_RD, `VPM_P_MISC_RD}))
			|| i_io.port == `VPM_P_LUT_RIDX
		: io_rd_hit);

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n)
			io_rdata_q <= 8'h00;
		else if (rd_io && io_rd_hit)
			io_rdata_q <= io_rd_d;
	end

	assign o_io_rdata = io_rdata_q;

	// Sync and clock fields straight from misc output
	assign o_vsync_pos = ~misc_q[`VPM_MISC_VPOL];
	assign o_hsync_pos = ~misc_q[`VPM_MISC_HPOL];
	assign o_vsize = vpm_pkg::vpm_vsize_e'(misc_q[`VPM_MISC_VPOL:`VPM_MISC_HPOL]);
	assign o_clk_sel = vpm_pkg::vpm_clk_e'(misc_q[`VPM_MISC_CLK_LSB+1:`VPM_MISC_CLK_LSB]);

	// Display fetch; bit 7 of each byte is the leftmost of eight pixels
	logic [2:0] bitpos;
	logic [3:0] pbits;
	assign bitpos = 3'h7 - i_scan_addr[2:0];
	assign pbits = {plane3[i_scan_addr >> 3][bitpos], plane2[i_scan_addr >> 3][bitpos],
		plane1[i_scan_addr >> 3][bitpos], plane0[i_scan_addr >> 3][bitpos]};

	// Linear mode samples nibbles twice; first fetch is the high nibble
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lo_nib_q <= 4'h0;
			pix_q <= '0;
		end else begin
			lo_nib_q <= pbits;
			pix_q.plane_bits <= pbits;
			// Mono pair {intensity, video}: 00 black ... 11 bright
			pix_q.mono_attr <= {pbits[2], pbits[0]};
			// Single plane: bit 0 is black, 1 intensified white
			if (gfx_reg_q[5][6])
				pix_q.lut_index <= i_scan_second ? {lo_nib_q, pbits} : pix_q.lut_index;
			else if (gfx_reg_q[6][0] && seq_reg_q[2][3:0] == 4'b0001)
				pix_q.lut_index <= {8{pbits[0]}} & 8'h0f;
			else
				pix_q.lut_index <= {4'h0, pbits};
		end
	end

	assign o_pix = pix_q;
endmodule // vpm_host_access

/* File: hw/vpm_pkg.sv */
// Types shared by the video plane host access block
package vpm_pkg;
	typedef enum logic [3:0] {
		VPM_MAP_A0_64K = 4'b0001,
		VPM_MAP_A0_128K = 4'b0010,
		VPM_MAP_B0_32K = 4'b0100,
		VPM_MAP_B8_32K = 4'b1000
	} vpm_win_e;
	typedef enum logic [4:0] {
		VPM_MD_MONO2   = 5'b00001,
		VPM_MD_MONO4   = 5'b00010,
		VPM_MD_PLANAR  = 5'b00100,
		VPM_MD_LINEAR  = 5'b01000,
		VPM_MD_TEXT    = 5'b10000
	} vpm_mode_e;
	typedef enum logic [1:0] {
		VPM_VS_RSVD = 2'b00,
		VPM_VS_400  = 2'b01,
		VPM_VS_350  = 2'b10,
		VPM_VS_480  = 2'b11
	} vpm_vsize_e;
	typedef enum logic [1:0] {
		VPM_CK_25   = 2'b00,
		VPM_CK_28   = 2'b01,
		VPM_CK_EXT  = 2'b10,
		VPM_CK_RSVD = 2'b11
	} vpm_clk_e;
	typedef struct packed {
		logic       req;
		logic       wr;
		logic [19:0] addr;
		logic [7:0] data;
	} vpm_mem_req_s;
	typedef struct packed {
		logic       req;
		logic       wr;
		logic [9:0] port;
		logic [7:0] data;
	} vpm_io_req_s;
	typedef struct packed {
		logic [3:0] plane_bits;
		logic [1:0] mono_attr;
		logic [7:0] lut_index;
	} vpm_pix_s;
endpackage

/* File: sim/tb_top.sv */
// Self-checking bench for the video plane host access block
`timescale 1ns/1ps
module tb_top;
	logic                  i_mclk = 1'b0;
	logic                  i_arst_n = 1'b0;
	logic                  sense = 1'b1;
	logic                  vret = 1'b1;
	logic                  disp = 1'b0;
	logic [9:0]            scan = 10'h000;
	logic                  scan2 = 1'b0;
	vpm_pkg::vpm_mem_req_s mem;
	vpm_pkg::vpm_io_req_s  io;
	logic                  mhit, iohit, h;
	logic [7:0]            mrd, iord, r;
	vpm_pkg::vpm_vsize_e   vsize;
	vpm_pkg::vpm_clk_e     clks;
	vpm_pkg::vpm_pix_s     pix;
	logic                  vpos, hpos;
	int                    fails = 0;
	int                    tests_run = 0;
	logic [7:0]            misc_tab [4] = '{8'h03, 8'h47, 8'h8b, 8'hcf};
	always #50 i_mclk = ~i_mclk;
	vpm_host_access #(.PLANE_AW(10)) i_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
		.i_mem(mem), .i_io(io), .i_switch_sense(sense), .i_vretrace(vret),
		.i_disp_en(disp), .i_scan_addr(scan), .i_scan_second(scan2),
		.o_mem_hit(mhit), .o_mem_rdata(mrd), .o_io_hit(iohit), .o_io_rdata(iord),
		.o_vsync_pos(vpos), .o_hsync_pos(hpos), .o_vsize(vsize),
		.o_clk_sel(clks), .o_pix(pix));
	vpm_host_model i_host (.i_mclk(i_mclk), .i_mem_hit(mhit), .i_mem_rdata(mrd),
		.i_io_hit(iohit), .i_io_rdata(iord), .o_mem(mem), .o_io(io));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [9:0] p, input logic [7:0] d);
		i_host.io(1'b1, p, d, h, r);
	endtask
	task automatic rdc(input logic [9:0] p, input logic [7:0] e);
		i_host.io(1'b0, p, 8'h00, h, r);
		chk(r, e);
	endtask
	task automatic hitc(input logic [9:0] p, input logic e);
		i_host.io(1'b0, p, 8'h00, h, r);
		chk({7'h0, h}, {7'h0, e});
	endtask
	task automatic gw(input logic [9:0] p, input logic [7:0] i, input logic [7:0] d);
		wr(p, i);
		wr(p + 10'h1, d);
	endtask
	task automatic mrc(input logic [19:0] a, input logic [7:0] e);
		i_host.mem(1'b0, a, 8'h00, h, r);
		chk({7'h0, h}, 8'h01);
		chk(r, e);
	endtask
	task automatic whc(input logic [9:0] p, input logic [7:0] d, input logic e);
		i_host.io(1'b1, p, d, h, r);
		chk({7'h0, h}, {7'h0, e});
	endtask
	task automatic pixc(input logic [9:0] a, input logic [7:0] e);
		scan = a;
		repeat (2) @(posedge i_mclk);
		#1;
		chk(pix.lut_index, e);
	endtask
	task automatic mhc(input logic [19:0] a, input logic e);
		i_host.mem(1'b0, a, 8'h00, h, r);
		chk({7'h0, h}, {7'h0, e});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge i_mclk);
		#1;
		i_arst_n = 1'b1;
		rdc(10'h3cc, 8'h00);
		rdc(10'h3c3, 8'h01);
		chk({6'h0, vpos, hpos}, 8'h03);
		mhc(20'ha0000, 1'b0);
		for (int k = 0; k < 4; k++) begin
			wr(10'h3c2, misc_tab[k]);
			rdc(10'h3cc, misc_tab[k]);
			chk({4'h0, vsize, clks}, {4'h0, misc_tab[k][7:6], misc_tab[k][3:2]});
		end
		rdc(10'h3da, 8'h09);
		hitc(10'h3ba, 1'b0);
		i_host.rmw(8'h01, 8'h00);
		rdc(10'h3cc, 8'hce);
		rdc(10'h3ba, 8'h09);
		hitc(10'h3da, 1'b0);
		wr(10'h3b4, 8'h0c);
		rdc(10'h3b4, 8'h0c);
		rdc(10'h3c2, 8'h10);
		rdc(10'h3c6, 8'hff);
		hitc(10'h3cd, 1'b0);
		wr(10'h3c0, 8'h12);
		wr(10'h3c0, 8'h21);
		rdc(10'h3c0, 8'h12);
		rdc(10'h3c1, 8'h21);
		gw(10'h3c4, 8'h04, 8'h06);
		gw(10'h3ce, 8'h06, 8'h05);
		gw(10'h3c4, 8'h02, 8'h0f);
		i_host.mem(1'b1, 20'ha0010, 8'h5a, h, r);
		for (int p = 0; p < 4; p++) begin
			gw(10'h3ce, 8'h04, p[7:0]);
			mrc(20'ha0010, 8'h5a);
		end
		gw(10'h3c4, 8'h02, 8'h04);
		i_host.mem(1'b1, 20'ha0010, 8'h3c, h, r);
		gw(10'h3ce, 8'h04, 8'h02);
		mrc(20'ha0010, 8'h3c);
		gw(10'h3ce, 8'h04, 8'h00);
		mrc(20'ha0010, 8'h5a);
		scan = 10'h086;
		repeat (2) @(posedge i_mclk);
		#1;
		chk({4'h0, pix.plane_bits}, 8'h0b);
		chk({6'h0, pix.mono_attr}, 8'h01);
		chk(pix.lut_index, 8'h0b);
		gw(10'h3ce, 8'h05, 8'h08);
		gw(10'h3ce, 8'h02, 8'h04);
		gw(10'h3ce, 8'h07, 8'h0f);
		mrc(20'ha0010, 8'h24);
		gw(10'h3ce, 8'h07, 8'h04);
		mrc(20'ha0010, 8'h3c);
		mhc(20'hb8000, 1'b0);
		gw(10'h3ce, 8'h06, 8'h0d);
		mhc(20'hb8000, 1'b1);
		mhc(20'ha0000, 1'b0);
		gw(10'h3ce, 8'h06, 8'h09);
		mhc(20'hb0000, 1'b1);
		whc(10'h3ba, 8'h5a, 1'b1);
		rdc(10'h3ca, 8'h5a);
		whc(10'h3da, 8'h00, 1'b0);
		gw(10'h3c4, 8'h02, 8'h01);
		pixc(10'h086, 8'h0f);
		pixc(10'h085, 8'h00);
		gw(10'h3ce, 8'h05, 8'h40);
		scan = 10'h086;
		@(posedge i_mclk);
		#1;
		scan = 10'h085;
		scan2 = 1'b1;
		@(posedge i_mclk);
		#1;
		scan2 = 1'b0;
		chk(pix.lut_index, 8'hb4);
		gw(10'h3ce, 8'h06, 8'h05);
		gw(10'h3c4, 8'h02, 8'h0f);
		gw(10'h3c4, 8'h04, 8'h0e);
		i_host.mem(1'b1, 20'ha0000, 8'h11, h, r);
		i_host.mem(1'b1, 20'ha0001, 8'h77, h, r);
		mrc(20'ha0000, 8'h11);
		mrc(20'ha0001, 8'h77);
		gw(10'h3c4, 8'h04, 8'h00);
		i_host.mem(1'b1, 20'ha0003, 8'h66, h, r);
		mrc(20'ha0003, 8'h66);
		wr(10'h3c0, 8'h05);
		i_arst_n = 1'b0;
		@(posedge i_mclk);
		#1;
		i_arst_n = 1'b1;
		rdc(10'h3cc, 8'h00);
		mhc(20'ha0000, 1'b0);
		wr(10'h3c0, 8'h03);
		rdc(10'h3c0, 8'h03);
		tally_and_finish();
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge i_mclk);
		fails++;
		tally_and_finish();
	end
endmodule // tb_top

/* File: sim/vpm_host_model.sv */
// Host processor model issuing memory and I/O cycles
`timescale 1ns/1ps
module vpm_host_model (
	input  wire logic            i_mclk,
	input  wire logic            i_mem_hit,
	input  wire logic [7:0]      i_mem_rdata,
	input  wire logic            i_io_hit,
	input  wire logic [7:0]      i_io_rdata,
	output vpm_pkg::vpm_mem_req_s o_mem,
	output vpm_pkg::vpm_io_req_s  o_io
);
	initial begin
		o_mem = '0;
		o_io = '0;
	end
	// One-cycle request; hit read mid-cycle, data after the edge
	task automatic io(input logic w, input logic [9:0] p, input logic [7:0] d,
		output logic h, output logic [7:0] r);
		@(posedge i_mclk);
		#1;
		o_io = {1'b1, w, p, d};
		@(negedge i_mclk);
		h = i_io_hit;
		@(posedge i_mclk);
		#1;
		r = i_io_rdata;
		o_io = '0;
	endtask
	task automatic mem(input logic w, input logic [19:0] a, input logic [7:0] d,
		output logic h, output logic [7:0] r);
		@(posedge i_mclk);
		#1;
		o_mem = {1'b1, w, a, d};
		@(negedge i_mclk);
		h = i_mem_hit;
		@(posedge i_mclk);
		#1;
		r = i_mem_rdata;
		o_mem = '0;
	endtask
	// Read first so reserved bits survive the update
	task automatic rmw(input logic [7:0] m, input logic [7:0] v);
		logic       h;
		logic [7:0] r;
		io(1'b0, 10'h3cc, 8'h00, h, r);
		io(1'b1, 10'h3c2, (r & ~m) | (v & m), h, r);
	endtask
endmodule // vpm_host_model

/* File: sim/vpm_props.sv */
// Port checker for the video plane host access block
`timescale 1ns/1ps
module vpm_props (
	input wire logic                  i_mclk,
	input wire logic                  i_arst_n,
	input wire vpm_pkg::vpm_mem_req_s i_mem,
	input wire vpm_pkg::vpm_io_req_s  i_io,
	input wire logic                  o_mem_hit,
	input wire logic                  o_io_hit,
	input wire logic [7:0]            o_io_rdata,
	input wire logic                  o_vsync_pos,
	input wire logic                  o_hsync_pos,
	input wire vpm_pkg::vpm_vsize_e   o_vsize,
	input wire vpm_pkg::vpm_clk_e     o_clk_sel
);
	logic [7:0] misc_q;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_arst_n);
	sequence misc_wr;
		i_io.req && i_io.wr && i_io.port == 10'h3c2 && o_io_hit;
	endsequence
	sequence misc_rd;
		i_io.req && !i_io.wr && i_io.port == 10'h3cc && o_io_hit;
	endsequence
	// Shadow of the last accepted misc output write to 3C2, for decode checks
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			misc_q <= 8'h00;
		end else if (i_io.req && i_io.wr && i_io.port == 10'h3c2 && o_io_hit) begin
			misc_q <= i_io.data;
		end
	end
	pol_follow_a: assert property (misc_wr |=> o_vsync_pos == !$past(i_io.data[7])
		&& o_hsync_pos == !$past(i_io.data[6])) else $error("sync polarity wrong");
	vsize_follow_a: assert property (misc_wr |=> o_vsize == $past(i_io.data[7:6]))
		else $error("vertical size wrong");
	clk_follow_a: assert property (misc_wr |=> o_clk_sel == $past(i_io.data[3:2]))
		else $error("clock select wrong");
	misc_readback_a: assert property (misc_wr ##1 !(i_io.req && i_io.wr) ##1 misc_rd
		|=> o_io_rdata == $past(i_io.data, 3)) else $error("misc readback wrong");
	size_pol_tie_a: assert property (o_vsize == {!o_vsync_pos, !o_hsync_pos})
		else $error("size and polarity disagree");
	ram_off_miss_a: assert property (i_mem.req && !misc_q[1] |-> !o_mem_hit)
		else $error("buffer decoded while disabled");
	stat_alias_miss_a: assert property (i_io.req
		&& i_io.port == (misc_q[0] ? 10'h3ba : 10'h3da) |-> !o_io_hit)
		else $error("status port decoded at wrong base");
	unmapped_miss_a: assert property (i_io.req
		&& i_io.port inside {10'h3cb, 10'h3cd} |-> !o_io_hit) else $error("unmapped hit");
endmodule // vpm_props
bind vpm_host_access vpm_props i_props (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
	.i_mem(i_mem), .i_io(i_io), .o_mem_hit(o_mem_hit), .o_io_hit(o_io_hit),
	.o_io_rdata(o_io_rdata), .o_vsync_pos(o_vsync_pos), .o_hsync_pos(o_hsync_pos),
	.o_vsize(o_vsize), .o_clk_sel(o_clk_sel));
